// ### logic/atr_pkg.sv
// Constants and carrier types for the conversion trigger router.
// Assumes one 100 MHz clock and an APB master on the register side.
//
// Contract
// - Three-bit code picks one of eight events
// - ADC1 events 2 and 4 by word 30
// - ADC1 events 6 to 8 options
// - ADC2 event 2 by word 31 bits 16/17
// - ADC2 event 4 by word 31 bits 24/25
// - ADC2 events 6 to 8 by word 32
// - Pad triggers sampled after input buffer
// - Timer-two and PWM triggers taken directly
// - Tick compare taken straight from timer
// - PWM SOC outputs merged into four triggers
// - Per-module route-select bits in words 35/36
// - Combined SOC-B is OR of all B
// - Unswitched SOC-A uses inverted route bit
// - Switched SOC-A uses set route bit
// - SOC-AB is SOC-B OR switched SOC-A
// - Each group starts on one of eight events
`default_nettype none
package atr_pkg;
	// Widths
	localparam int ADDR_W = 8, T1_W = 32, T2_W = 18, PB_W = 2, PWM_N = 7;
	localparam int EV_N = 8, GRP_N = 3, SRC_W = 3, SRC_STRIDE = 4;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_W30 = 8'h00, OFS_W31 = 8'h04, OFS_W32 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_W35 = 8'h0c, OFS_W36 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_SRC = 8'h14, OFS_STAT = 8'h18;
	// Reset values
	localparam logic [31:0] W30_RST = 32'h0000_0001, WX_RST = 32'h0000_0000;
	// Word 30 mode bits
	localparam int MODE_PRI = 0, MODE_ALT = 1;
	// Option control bit positions, A bit then B bit
	localparam int C1_EV2 = 8, C1_EV4 = 16, C1_EV6 = 24, C1_EV7 = 0, C1_EV8A = 16, C1_EV8B = 8;
	localparam int C2_EV2 = 16, C2_EV4 = 24, C2_EV6 = 0, C2_EV7 = 8, C2_EV8 = 16;
	// Route-select bit positions inside words 35/36
	localparam int RS_B0 = 0, RS_B1 = 8, RS_B2 = 16, RS_B3 = 24;
	// Event indices
	localparam int EV1 = 0, EV2 = 1, EV3 = 2, EV4 = 3, EV5 = 4, EV6 = 5, EV7 = 6, EV8 = 7;
	// Source channel indices
	localparam int T1_P2 = 8, T1_P3 = 10, T1_P5 = 12, T1_P6 = 14;
	localparam int T1_A3 = 27, T1_A5 = 17, T1_A6 = 19, T1_A7 = 11;
	localparam int T2_A2 = 5, T2_B6 = 1, T2_A8 = 13, PB_P7 = 0, PB_P8 = 1;
	// Group indices
	localparam int GRP_EV = 0, GRP_1 = 1, GRP_2 = 2;
	// Status fields
	localparam int ST_EV1 = 0, ST_EV2 = 8, ST_PWM = 16, ST_G1 = 24, ST_G2 = 28;
	// Pad-side inputs, asynchronous to mclk
	typedef struct packed {
		logic            adc1_external_event_pin;
		logic            adc2_external_event_pin;
		logic [PB_W-1:0] port_b_bits;
		logic [T1_W-1:0] timer_one_channels;
	} atr_pad_t;
	// On-chip module outputs, already on mclk
	typedef struct packed {
		logic [T2_W-1:0]  timer_two_channels;
		logic             tick_timer_compare0;
		logic [PWM_N-1:0] pwm_start_conversion_a;
		logic [PWM_N-1:0] pwm_start_conversion_b;
	} atr_int_t;
	// Merged PWM triggers
	typedef struct packed {
		logic combined_soc_b_trigger;
		logic unswitched_soc_a_trigger;
		logic switched_soc_a_trigger;
		logic soc_ab_trigger;
	} atr_pwm_trig_t;
	// Option control pair
	typedef struct packed {
		logic b;
		logic a;
	} atr_opt_t;
endpackage
`default_nettype wire

// ### logic/atr_soc_combine.sv
// Merges the start-of-conversion outputs of all PWM modules.
// Assumes route-select bits come from registered control words.
`default_nettype none
module atr_soc_combine
	import atr_pkg::*;
(
	// PWM start-of-conversion outputs
	input  wire logic [PWM_N-1:0] soc_a,
	input  wire logic [PWM_N-1:0] soc_b,
	// Per-module route-select bits
	input  wire logic [PWM_N-1:0] route_sel,
	// Merged triggers
	output atr_pwm_trig_t         trig
);
	// Plain OR network, no storage
	always_comb
	begin
		trig.combined_soc_b_trigger   = |soc_b;
		trig.unswitched_soc_a_trigger = |(soc_a & ~route_sel);
		trig.switched_soc_a_trigger   = |(soc_a & route_sel);
		trig.soc_ab_trigger           = (|soc_b) | (|(soc_a & route_sel));
	end
endmodule
`default_nettype wire

// ### logic/atr_event_select.sv
// Builds the eight event signals offered to one converter.
// Assumes pad sources already synchronised to mclk.
`default_nettype none
module atr_event_select
	import atr_pkg::*;
(
	// Mode from word 30
	input  wire logic            primary,
	input  wire logic            alternate,
	// Sources
	input  wire logic            evt_pin,
	input  wire logic [T1_W-1:0] t1,
	input  wire logic [T2_W-1:0] t2,
	input  wire logic [PB_W-1:0] port_b,
	input  wire logic            tick,
	input  wire atr_pwm_trig_t   pwm,
	// Option controls for events 2, 4, 6, 7, 8
	input  wire atr_opt_t        ctl_ev2,
	input  wire atr_opt_t        ctl_ev4,
	input  wire atr_opt_t        ctl_ev6,
	input  wire atr_opt_t        ctl_ev7,
	input  wire atr_opt_t        ctl_ev8,
	// Event lines
	output logic [EV_N-1:0]      events
);
	// Option A wins, option B only when A is off
	function automatic logic pick(input atr_opt_t c, input logic a, input logic b);
		return c.a ? a : (c.b & b);
	endfunction

	// Event table per mode; neither mode gives no events
	always_comb
	begin
		events = '0;
		if (primary)
		begin
			events[EV1] = evt_pin;
			events[EV2] = t1[T1_P2];
			events[EV3] = t1[T1_P3];
			events[EV4] = tick;
			events[EV5] = t1[T1_P5];
			events[EV6] = t1[T1_P6];
			events[EV7] = port_b[PB_P7];
			events[EV8] = port_b[PB_P8];
		end
		else if (alternate)
		begin
			events[EV1] = evt_pin;
			events[EV3] = t1[T1_A3];
			events[EV5] = t1[T1_A5];
			events[EV2] = pick(ctl_ev2, t2[T2_A2], pwm.combined_soc_b_trigger);
			events[EV4] = pick(ctl_ev4, tick, pwm.unswitched_soc_a_trigger);
			events[EV6] = pick(ctl_ev6, t1[T1_A6], t2[T2_B6]);
			events[EV7] = pick(ctl_ev7, t1[T1_A7], pwm.switched_soc_a_trigger);
			events[EV8] = pick(ctl_ev8, t2[T2_A8], pwm.soc_ab_trigger);
		end
	end
endmodule
`default_nettype wire

// ### logic/atr_trigger_router.sv
// Conversion trigger router for two converters, with APB registers.
// Assumes an APB master on mclk, pads asynchronous, modules on mclk.
//
// Added by the designer: register access over APB and the address map.
`default_nettype none
module atr_trigger_router
	import atr_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Trigger sources
	input  wire atr_pad_t          pad_in,
	input  wire atr_int_t          int_in,
	// Group triggers, index 0 event group, 1 group 1, 2 group 2
	output logic [GRP_N-1:0]       adc1_group_trigger,
	output logic [GRP_N-1:0]       adc2_group_trigger
);
	// Control words
	logic [31:0] pin_mux_control_word_30;   // Mode and ADC1 options
	logic [31:0] pin_mux_control_word_31;   // ADC1/ADC2 options
	logic [31:0] pin_mux_control_word_32;   // ADC1/ADC2 options
	logic [31:0] pin_mux_control_word_35;   // Route selects 1-4
	logic [31:0] pin_mux_control_word_36;   // Route selects 5-7
	logic [31:0] source_select;             // Six group codes

	// Pad synchroniser stages
	atr_pad_t pad_s1;   // First stage, read by pad_s2 only
	atr_pad_t pad_s2;   // Second stage
	atr_pad_t pad_s3;   // Third stage
	atr_pad_t pad_f;    // Accepted pad level

	// Internal combinational nets
	logic [PWM_N-1:0] route_sel;   // Route bits gathered
	atr_pwm_trig_t    pwm_trig;    // Merged PWM triggers
	logic             primary;     // Primary source set
	logic             alternate;   // Alternate source set
	logic [EV_N-1:0]  adc1_ev;     // ADC1 event lines
	logic [EV_N-1:0]  adc2_ev;     // ADC2 event lines
	logic [SRC_W-1:0] sel1 [GRP_N];   // ADC1 group codes
	logic [SRC_W-1:0] sel2 [GRP_N];   // ADC2 group codes
	logic             adc1_ev8_b;     // ADC1 event 8 option B enable

	// APB decode nets
	logic        setup;       // Setup cycle
	logic        access;      // Access cycle
	logic        mapped;      // Address hits a register
	logic        wr_ok;       // Write may take effect
	logic [31:0] status;      // Live state word
	logic [31:0] next_prdata; // Read data for this address

	// Decode of APB phases
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;

	// Address decode
	always_comb
	begin
		case (paddr)
			OFS_W30, OFS_W31, OFS_W32,
			OFS_W35, OFS_W36, OFS_SRC, OFS_STAT:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	// Status is read-only, so a write to it is an error
	assign wr_ok   = mapped & (paddr != OFS_STAT);
	assign pslverr = access & (~mapped | (pwrite & ~wr_ok));

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
	                                      input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Control register writes, taken at the access edge
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_mux_control_word_30 <= W30_RST;
			pin_mux_control_word_31 <= WX_RST;
			pin_mux_control_word_32 <= WX_RST;
			pin_mux_control_word_35 <= WX_RST;
			pin_mux_control_word_36 <= WX_RST;
			source_select           <= WX_RST;
		end
		else if (access && pwrite && wr_ok)
		begin
			case (paddr)
				OFS_W30: pin_mux_control_word_30 <= merge(pin_mux_control_word_30, pwdata, pstrb);
				OFS_W31: pin_mux_control_word_31 <= merge(pin_mux_control_word_31, pwdata, pstrb);
				OFS_W32: pin_mux_control_word_32 <= merge(pin_mux_control_word_32, pwdata, pstrb);
				OFS_W35: pin_mux_control_word_35 <= merge(pin_mux_control_word_35, pwdata, pstrb);
				OFS_W36: pin_mux_control_word_36 <= merge(pin_mux_control_word_36, pwdata, pstrb);
				OFS_SRC: source_select <= merge(source_select, pwdata, pstrb);
				default: source_select <= source_select;
			endcase
		end
	end

	// Status word: event lines, PWM triggers, group triggers
	always_comb
	begin
		status                   = '0;
		status[ST_EV1 +: EV_N]   = adc1_ev;
		status[ST_EV2 +: EV_N]   = adc2_ev;
		status[ST_PWM +: 4]      = pwm_trig;
		status[ST_G1 +: GRP_N]   = adc1_group_trigger;
		status[ST_G2 +: GRP_N]   = adc2_group_trigger;
	end

	// Read mux
	always_comb
	begin
		case (paddr)
			OFS_W30:  next_prdata = pin_mux_control_word_30;
			OFS_W31:  next_prdata = pin_mux_control_word_31;
			OFS_W32:  next_prdata = pin_mux_control_word_32;
			OFS_W35:  next_prdata = pin_mux_control_word_35;
			OFS_W36:  next_prdata = pin_mux_control_word_36;
			OFS_SRC:  next_prdata = source_select;
			OFS_STAT: next_prdata = status;
			default:  next_prdata = '0;
		endcase
	end

	// Read data latched in the setup cycle, held through access
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata <= '0;
		end
		else if (setup && !pwrite)
		begin
			prdata <= next_prdata;
		end
	end

	// Pad synchroniser: three stages, stages two and three must agree
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pad_s1 <= '0;
			pad_s2 <= '0;
			pad_s3 <= '0;
		end
		else
		begin
			pad_s1 <= pad_in;
			pad_s2 <= pad_s1;
			pad_s3 <= pad_s2;
		end
	end

	// Accepted level changes only where stages agree
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pad_f <= '0;
		end
		else
		begin
			pad_f <= (pad_s2 & pad_s3) | (pad_f & (pad_s2 ^ pad_s3));
		end
	end

	// Gather route-select bits of the seven PWM modules
	assign route_sel = {pin_mux_control_word_36[RS_B2], pin_mux_control_word_36[RS_B1],
	                    pin_mux_control_word_36[RS_B0], pin_mux_control_word_35[RS_B3],
	                    pin_mux_control_word_35[RS_B2], pin_mux_control_word_35[RS_B1],
	                    pin_mux_control_word_35[RS_B0]};

	// PWM merge network
	atr_soc_combine u_soc
	(
		.soc_a     (int_in.pwm_start_conversion_a),
		.soc_b     (int_in.pwm_start_conversion_b),
		.route_sel (route_sel),
		.trig      (pwm_trig)
	);

	// Mode decode; primary has priority over alternate
	assign primary   = pin_mux_control_word_30[MODE_PRI];
	assign alternate = ~pin_mux_control_word_30[MODE_PRI] & pin_mux_control_word_30[MODE_ALT];

	// ADC1 event 8 option B also needs word 31 bit 8 clear
	assign adc1_ev8_b = pin_mux_control_word_31[C1_EV8B + 1] & ~pin_mux_control_word_31[C1_EV8B];

	// ADC1 events, controls in words 30 to 32
	atr_event_select u_ev1
	(
		.primary   (primary),
		.alternate (alternate),
		.evt_pin   (pad_f.adc1_external_event_pin),
		.t1        (pad_f.timer_one_channels),
		.t2        (int_in.timer_two_channels),
		.port_b    (pad_f.port_b_bits),
		.tick      (int_in.tick_timer_compare0),
		.pwm       (pwm_trig),
		.ctl_ev2   (pin_mux_control_word_30[C1_EV2 +: 2]),
		.ctl_ev4   (pin_mux_control_word_30[C1_EV4 +: 2]),
		.ctl_ev6   (pin_mux_control_word_30[C1_EV6 +: 2]),
		.ctl_ev7   (pin_mux_control_word_31[C1_EV7 +: 2]),
		.ctl_ev8   ({adc1_ev8_b, pin_mux_control_word_32[C1_EV8A]}),
		.events    (adc1_ev)
	);

	// ADC2 events, controls in words 31 and 32
	atr_event_select u_ev2
	(
		.primary   (primary),
		.alternate (alternate),
		.evt_pin   (pad_f.adc2_external_event_pin),
		.t1        (pad_f.timer_one_channels),
		.t2        (int_in.timer_two_channels),
		.port_b    (pad_f.port_b_bits),
		.tick      (int_in.tick_timer_compare0),
		.pwm       (pwm_trig),
		.ctl_ev2   (pin_mux_control_word_31[C2_EV2 +: 2]),
		.ctl_ev4   (pin_mux_control_word_31[C2_EV4 +: 2]),
		.ctl_ev6   (pin_mux_control_word_32[C2_EV6 +: 2]),
		.ctl_ev7   (pin_mux_control_word_32[C2_EV7 +: 2]),
		.ctl_ev8   (pin_mux_control_word_32[C2_EV8 +: 2]),
		.events    (adc2_ev)
	);

	// Group code fields, ADC1 in bits 0 to 11, ADC2 in bits 12 to 23
	for (genvar g = 0; g < GRP_N; g++)
	begin : g_sel
		assign sel1[g] = source_select[g*SRC_STRIDE +: SRC_W];
		assign sel2[g] = source_select[(g+GRP_N)*SRC_STRIDE +: SRC_W];
	end

	// Group triggers: code indexes the event lines, registered
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			adc1_group_trigger <= '0;
			adc2_group_trigger <= '0;
		end
		else
		begin
			for (int g = 0; g < GRP_N; g++)
			begin
				adc1_group_trigger[g] <= adc1_ev[sel1[g]];
				adc2_group_trigger[g] <= adc2_ev[sel2[g]];
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// Code to event, one cycle later
	chk_group_code_index: assert property (
		adc1_group_trigger[GRP_1] == $past(adc1_ev[sel1[GRP_1]])
		&& adc2_group_trigger[GRP_2] == $past(adc2_ev[sel2[GRP_2]]))
		else $error("group trigger does not follow its event code");

	// Primary set uses port B and tick compare
	chk_primary_sources: assert property (
		primary |-> adc1_ev[EV8] == pad_f.port_b_bits[PB_P8]
		&& adc2_ev[EV4] == int_in.tick_timer_compare0)
		else $error("primary event table wrong");

	// Alternate fixed events
	chk_alt_fixed_events: assert property (
		alternate |-> adc1_ev[EV3] == pad_f.timer_one_channels[T1_A3]
		&& adc2_ev[EV5] == pad_f.timer_one_channels[T1_A5])
		else $error("alternate fixed event wrong");

	// ADC1 event 2 option B, when option A is off
	chk_adc1_event_two: assert property (
		alternate && !pin_mux_control_word_30[C1_EV2]
		|-> adc1_ev[EV2] == (pin_mux_control_word_30[C1_EV2 + 1] & pwm_trig.combined_soc_b_trigger))
		else $error("ADC1 event 2 option B wrong");

	// ADC1 event 8 off when no control bit set
	chk_adc1_event_eight: assert property (
		alternate && !pin_mux_control_word_32[C1_EV8A] && !pin_mux_control_word_31[C1_EV8B + 1]
		|-> !adc1_ev[EV8])
		else $error("ADC1 event 8 active with no option");

	// ADC1 event 8 option B blocked while word 31 bit 8 is set
	chk_adc1_ev8_gate: assert property (
		alternate && !pin_mux_control_word_32[C1_EV8A] && pin_mux_control_word_31[C1_EV8B]
		|-> !adc1_ev[EV8])
		else $error("ADC1 event 8 option B taken with bit 8 set");

	// ADC2 event 2 option A
	chk_adc2_event_two: assert property (
		alternate && pin_mux_control_word_31[C2_EV2]
		|-> adc2_ev[EV2] == int_in.timer_two_channels[T2_A2])
		else $error("ADC2 event 2 option A wrong");

	// ADC2 event 4 option B
	chk_adc2_event_four: assert property (
		alternate && !pin_mux_control_word_31[C2_EV4] && pin_mux_control_word_31[C2_EV4 + 1]
		|-> adc2_ev[EV4] == pwm_trig.unswitched_soc_a_trigger)
		else $error("ADC2 event 4 option B wrong");

	// ADC2 event 7 option A
	chk_adc2_event_seven: assert property (
		alternate && pin_mux_control_word_32[C2_EV7]
		|-> adc2_ev[EV7] == pad_f.timer_one_channels[T1_A7])
		else $error("ADC2 event 7 option A wrong");

	// Steady pad level reaches the event path within four edges
	chk_pad_settles: assert property (
		$stable(pad_in.adc1_external_event_pin) [*4]
		|-> pad_f.adc1_external_event_pin == $past(pad_in.adc1_external_event_pin, 3))
		else $error("pad level not accepted after settling");

	// PWM merge equation for SOC-AB
	chk_pwm_merge: assert property (
		pwm_trig.soc_ab_trigger == (|int_in.pwm_start_conversion_b
		| |(int_in.pwm_start_conversion_a & route_sel)))
		else $error("SOC-AB trigger wrong");

	// Scenarios
	cov_primary_fire: cover property (primary && adc1_group_trigger[GRP_EV]);
	cov_alt_pwm_fire: cover property (alternate && pwm_trig.soc_ab_trigger && adc2_group_trigger[GRP_1]);
	cov_apb_error: cover property (access && pslverr);
	cov_alt_group2_fire: cover property (alternate && adc1_group_trigger[GRP_2]);
endmodule
`default_nettype wire

// ### testbench/tb_atr_trigger_router.sv
// Self-checking bench for the conversion trigger router.
// Assumes zero-wait APB, 3-flop pad sync, registered group triggers.
`default_nettype none
module tb_atr_trigger_router
	import atr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Design ports
	logic                mclk;
	logic                arst_n;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata;
	logic [3:0]          pstrb;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	atr_pad_t            pad_in;
	atr_int_t            int_in;
	logic [GRP_N-1:0]    adc1_group_trigger;
	logic [GRP_N-1:0]    adc2_group_trigger;
	// Bench state
	integer              mismatches;
	integer              n_checks;
	integer              seed;
	integer              k;
	logic [31:0]         sh [0:5];
	logic [31:0]         rd;
	logic                err;
	logic [63:0]         rv;

	atr_trigger_router atr_trigger_router_i (
		.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .int_in(int_in),
		.adc1_group_trigger(adc1_group_trigger), .adc2_group_trigger(adc2_group_trigger)
	);

	// 100 MHz clock
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// Option A wins, else option B, else nothing
	function automatic logic sel2(input logic a, input logic b, input logic x, input logic y);
		return a ? x : (b ? y : 1'b0);
	endfunction

	// Merged PWM triggers from the shadow route bits
	function automatic atr_pwm_trig_t exp_pwm(input atr_int_t n);
		logic [6:0]    rs;
		atr_pwm_trig_t t;
		rs = {sh[4][16], sh[4][8], sh[4][0], sh[3][24], sh[3][16], sh[3][8], sh[3][0]};
		t.combined_soc_b_trigger = |n.pwm_start_conversion_b;
		t.unswitched_soc_a_trigger = |(n.pwm_start_conversion_a & ~rs);
		t.switched_soc_a_trigger = |(n.pwm_start_conversion_a & rs);
		t.soc_ab_trigger = t.combined_soc_b_trigger | t.switched_soc_a_trigger;
		return t;
	endfunction

	// Eight event lines of one converter
	function automatic logic [7:0] exp_ev(input logic second, input atr_pad_t p, input atr_int_t n);
		atr_pwm_trig_t w;
		logic          e;
		logic [9:0]    c;
		logic [31:0]   t1;
		logic [17:0]   t2;
		w = exp_pwm(n);
		t1 = p.timer_one_channels;
		t2 = n.timer_two_channels;
		e = second ? p.adc2_external_event_pin : p.adc1_external_event_pin;
		// Option pairs {a,b} for events 2, 4, 6, 7, 8
		if (second)
			c = {sh[1][16], sh[1][17], sh[1][24], sh[1][25], sh[2][0], sh[2][1], sh[2][8], sh[2][9],
				sh[2][16], sh[2][17]};
		else
			c = {sh[0][8], sh[0][9], sh[0][16], sh[0][17], sh[0][24], sh[0][25], sh[1][0], sh[1][1],
				sh[2][16], sh[1][9] & ~sh[1][8]};
		// Primary source set
		if (sh[0][0])
			return {p.port_b_bits, t1[14], t1[12], n.tick_timer_compare0, t1[10], t1[8], e};
		// Neither mode bit set
		if (!sh[0][1])
			return 8'h00;
		return {sel2(c[1], c[0], t2[13], w.soc_ab_trigger), sel2(c[3], c[2], t1[11], w.switched_soc_a_trigger),
			sel2(c[5], c[4], t1[19], t2[1]), t1[17], sel2(c[7], c[6], n.tick_timer_compare0,
			w.unswitched_soc_a_trigger), t1[27], sel2(c[9], c[8], t2[5], w.combined_soc_b_trigger), e};
	endfunction

	// Group triggers picked by three codes
	function automatic logic [2:0] exp_grp(input logic [7:0] ev, input logic [11:0] s);
		return {ev[s[10:8]], ev[s[6:4]], ev[s[2:0]]};
	endfunction

	// Value comparison
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask

	// Verdict and end of run
	task automatic end_sim;
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		integer i;
		integer b;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		// Bounded wait ran out
		if (i == 20)
		begin
			mismatches++;
			end_sim;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// Shadow follows byte strobes of mapped writable words
		if (wr && a < OFS_STAT)
			for (b = 0; b < 4; b++)
				if (s[b])
					sh[a >> 2][8 * b +: 8] = d[8 * b +: 8];
		@(posedge mclk);
	endtask

	// Compare both trigger outputs and the status word
	task automatic check_trig;
		logic [7:0]    e1;
		logic [7:0]    e2;
		atr_pwm_trig_t w;
		e1 = exp_ev(1'b0, pad_in, int_in);
		e2 = exp_ev(1'b1, pad_in, int_in);
		w = exp_pwm(int_in);
		chk("adc1_group_trigger", {29'h0, exp_grp(e1, sh[5][11:0])}, {29'h0, adc1_group_trigger});
		chk("adc2_group_trigger", {29'h0, exp_grp(e2, sh[5][23:12])}, {29'h0, adc2_group_trigger});
		apb(1'b0, OFS_STAT, 32'h0, 4'h0);
		chk("status", {1'b0, exp_grp(e2, sh[5][23:12]), 1'b0, exp_grp(e1, sh[5][11:0]), 4'h0, w, e2, e1}, rd);
	endtask

	// Main sequence
	initial
	begin
		seed = 34239;
		mismatches = 0;
		n_checks = 0;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		pad_in = '0;
		int_in = '0;
		sh[0] = W30_RST;
		for (k = 1; k < 6; k++)
			sh[k] = WX_RST;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		// Reset values of the control words
		for (k = 0; k < 6; k++)
		begin
			apb(1'b0, 8'(k * 4), 32'h0, 4'h0);
			chk("reset value", sh[k], rd);
			chk("read error", 32'h0, {31'h0, err});
		end
		// Refused accesses
		apb(1'b0, 8'h1c, 32'h0, 4'h0);
		chk("unmapped read data", 32'h0, rd);
		chk("unmapped read error", 32'h1, {31'h0, err});
		apb(1'b1, OFS_STAT, 32'hffff_ffff, 4'hf);
		chk("status write error", 32'h1, {31'h0, err});
		apb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		chk("unmapped write error", 32'h1, {31'h0, err});
		// Tick compare reaches every group one cycle later
		apb(1'b1, OFS_SRC, 32'h0033_3333, 4'hf);
		int_in.tick_timer_compare0 <= 1'b1;
		#1;
		chk("tick before edge", 32'h0, {26'h0, adc2_group_trigger, adc1_group_trigger});
		@(posedge mclk);
		#1;
		chk("tick after edge", 32'h3f, {26'h0, adc2_group_trigger, adc1_group_trigger});
		@(posedge mclk);
		check_trig;
		// Event pins not selected by any code must not fire a group
		int_in.tick_timer_compare0 <= 1'b0;
		pad_in.adc1_external_event_pin <= 1'b1;
		pad_in.adc2_external_event_pin <= 1'b1;
		repeat (7) @(posedge mclk);
		#1;
		chk("deselected pad", 32'h0, {26'h0, adc2_group_trigger, adc1_group_trigger});
		@(posedge mclk);
		// Random configuration and sources, pads given time to sync
		for (k = 0; k < 300; k++)
		begin
			apb(1'b1, 8'((($random(seed) & 32'h7fff_ffff) % 6) * 4), $random(seed), 4'($random(seed)));
			rv = {$random(seed), $random(seed)};
			pad_in <= rv[$bits(atr_pad_t)-1:0];
			rv = {$random(seed), $random(seed)};
			int_in <= rv[$bits(atr_int_t)-1:0];
			repeat (7) @(posedge mclk);
			check_trig;
		end
		end_sim;
	end
endmodule
`default_nettype wire
